// >>> pms_pkg.sv
// package: constants and types shared by both ends of the sideband link
package pms_pkg;
  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned RESET_MIN_NS = 1000;
  localparam int unsigned RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_DONE_NS = 2000;
  localparam int unsigned INIT_DONE_CYCLES = INIT_DONE_NS / CLK_PERIOD_NS;
  localparam int unsigned SCL_HALF_CYCLES = 125;
  // ----------------------------------------------------------------
  // memory map of the module
  // ----------------------------------------------------------------
  localparam logic [7:0] DEV_ADDR = 8'h50;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_FLAGS = 8'h03;
  localparam logic [7:0] ADDR_CONTROL = 8'h1a;
  localparam int unsigned STATUS_NOT_READY = 0;
  localparam int unsigned STATUS_HIGH_POWER = 1;
  localparam int unsigned FLAG_RESET_DONE = 0;
  localparam int unsigned FLAG_FAULT = 1;
  localparam int unsigned CONTROL_HP_ENABLE = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // ----------------------------------------------------------------
  // host register port
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_RDATA = 4'h1;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h2;
  localparam logic [3:0] REG_IRQ_MASK = 4'h3;
  localparam logic [3:0] REG_PINS = 4'h4;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_ATTN = 1;
  localparam int unsigned IRQ_PRESENT = 2;
  typedef enum logic [1:0] {PMS_OP_READ, PMS_OP_WRITE} pms_op_t;
endpackage : pms_pkg

// >>> pms_link_if.sv
// interface: sideband pins joining the host controller and the module
`timescale 1ns/10ps
interface pms_link_if;
  logic module_select_n;
  logic module_reset_n;
  logic init_control_select;
  logic init_control_select_oe;
  logic module_present_n;
  logic interrupt_n_oe;
  logic scl;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_mod_o;
  logic sda_mod_oe;
  // resolved wire levels: pull-ups on every open-drain line
  wire interrupt_n = interrupt_n_oe ? 1'b0 : 1'b1;
  wire sda = (sda_host_oe && !sda_host_o) || (sda_mod_oe && !sda_mod_o) ? 1'b0 : 1'b1;
  wire init_pin = init_control_select_oe ? init_control_select : 1'b1;
  wire scl_pin = scl_oe ? scl : 1'b1;
  modport module_end (input module_select_n, input module_reset_n, input init_pin,
    input scl_pin, input sda, output module_present_n, output interrupt_n_oe,
    output sda_mod_o, output sda_mod_oe);
  modport host_end (output module_select_n, output module_reset_n,
    output init_control_select, output init_control_select_oe, output scl, output scl_oe,
    output sda_host_o, output sda_host_oe, input module_present_n, input interrupt_n,
    input sda);
endinterface : pms_link_if

// >>> pms_sync.sv
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pms_sync #(
  parameter logic INIT = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pin in, clean level out
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  // a change counts once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      level <= INIT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule : pms_sync

// >>> pms_module_end.sv
// module: sideband control of the pluggable module, with a two-wire slave
`timescale 1ns/10ps
// How it works
// [RQ1] answer the serial bus only while selected
// [RQ2] host gives each module its own select
// [RQ3] clock and data lines carry memory map access
// [RQ4] long reset low restores all defaults
// [RQ5] host ignores status until reset done
// [RQ6] done: interrupt posted with not-ready clear
// [RQ7] power-up posts done interrupt unprompted
// [RQ8] init select pin pulled up internally
// [RQ9] high pin: low power until software enables
// [RQ10] low pin: high power after init
// [RQ11] host holds init select constant
// [RQ12] presence line grounded while inserted
// [RQ13] interrupt low flags fault or status
// [RQ14] host reads memory map to find cause
// [RQ15] interrupt line only pulled low or released
// [RQ16] reset low time filtered by parameter
// [RQ17] not-ready set from reset until done
module pms_module_end #(
  parameter int unsigned RESET_MIN = pms_pkg::RESET_MIN_CYCLES,
  parameter int unsigned INIT_TIME = pms_pkg::INIT_DONE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link pins
  pms_link_if.module_end link,
  // local fault source from the datapath
  input wire logic fault_event,
  // power state to the datapath
  output logic high_power
);
  typedef enum logic [2:0] {PMS_S_IDLE, PMS_S_ADDR, PMS_S_REG, PMS_S_WDATA, PMS_S_RDATA,
    PMS_S_ACK, PMS_S_WAIT} pms_state_t;
  typedef enum logic [1:0] {PMS_P_RESET, PMS_P_INIT, PMS_P_READY} pms_phase_t;
  logic sel_n;
  logic rst_pin;
  logic init_pin;
  logic scl;
  logic sda;
  logic scl_d;
  logic sda_d;
  logic [15:0] rst_cnt;
  logic [15:0] init_cnt;
  pms_phase_t phase;
  logic not_ready;
  logic [7:0] flags;
  logic [7:0] control;
  pms_state_t state;
  pms_state_t after_ack;
  logic [7:0] shift;
  logic [3:0] bitn;
  logic [7:0] reg_ptr;
  logic addr_ok;
  logic ack_is_mine;
  // ----------------------------------------------------------------
  // pin inputs
  // ----------------------------------------------------------------
  pms_sync #(.INIT(1'b1)) u_sel (.clk(clk), .nrst(nrst), .pin(link.module_select_n),
    .level(sel_n));
  pms_sync #(.INIT(1'b1)) u_rst (.clk(clk), .nrst(nrst), .pin(link.module_reset_n),
    .level(rst_pin));
  // undriven pin resolves high in the carrier, like a pull-up
  pms_sync #(.INIT(1'b1)) u_init (.clk(clk), .nrst(nrst), .pin(link.init_pin),
    .level(init_pin)); // RQ8
  pms_sync #(.INIT(1'b1)) u_scl (.clk(clk), .nrst(nrst), .pin(link.scl_pin), .level(scl));
  pms_sync #(.INIT(1'b1)) u_sda (.clk(clk), .nrst(nrst), .pin(link.sda), .level(sda));

  function automatic logic [7:0] map_read(input logic [7:0] a, input logic nr, input logic hp,
      input logic [7:0] fl, input logic [7:0] ct);
    logic [7:0] v;
    v = 8'h00;
    if (a == pms_pkg::ADDR_STATUS) begin
      v[pms_pkg::STATUS_NOT_READY] = nr;
      v[pms_pkg::STATUS_HIGH_POWER] = hp;
    end else if (a == pms_pkg::ADDR_FLAGS) begin
      v = fl;
    end else if (a == pms_pkg::ADDR_CONTROL) begin
      v = ct;
    end
    return v;
  endfunction : map_read

  // ----------------------------------------------------------------
  // reset filter and power-up sequence
  // ----------------------------------------------------------------
  // short glitches on the reset pin never reach the sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_cnt <= 16'h0000;
    end else if (rst_pin) begin
      rst_cnt <= 16'h0000;
    end else if (rst_cnt != 16'hffff) begin
      rst_cnt <= rst_cnt + 16'h0001; // RQ16
    end
  end

  wire reset_hit = (rst_cnt == 16'(RESET_MIN)); // RQ4 RQ16

  // power-up starts in the reset phase, so done is posted unprompted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase <= PMS_P_RESET; // RQ7
      init_cnt <= 16'h0000;
      not_ready <= 1'b1;
    end else if (reset_hit || !rst_pin && phase == PMS_P_RESET) begin
      phase <= PMS_P_RESET;
      init_cnt <= 16'h0000;
      not_ready <= 1'b1; // RQ17
    end else begin
      unique case (phase)
        PMS_P_RESET: begin
          phase <= PMS_P_INIT;
        end
        PMS_P_INIT: begin
          if (init_cnt == 16'(INIT_TIME)) begin
            phase <= PMS_P_READY;
            not_ready <= 1'b0; // RQ6 RQ17
          end else begin
            init_cnt <= init_cnt + 16'h0001;
          end
        end
        PMS_P_READY: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // power mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      high_power <= 1'b0;
    end else if (phase != PMS_P_READY) begin
      high_power <= 1'b0;
    end else if (init_pin) begin
      high_power <= control[pms_pkg::CONTROL_HP_ENABLE]; // RQ9
    end else begin
      high_power <= 1'b1; // RQ10
    end
  end

  // ----------------------------------------------------------------
  // two-wire slave
  // ----------------------------------------------------------------
  wire start_c = scl && scl_d && sda_d && !sda;
  wire stop_c = scl && scl_d && !sda_d && sda;
  wire scl_rise = scl && !scl_d;
  wire scl_fall = !scl && scl_d;
  wire flag_clr = (state == PMS_S_WDATA) && scl_rise && bitn == 4'd7 && !sel_n &&
    reg_ptr == pms_pkg::ADDR_FLAGS;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // bus state; deselect drops any transfer in flight
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= PMS_S_IDLE;
      after_ack <= PMS_S_IDLE;
      shift <= 8'h00;
      bitn <= 4'h0;
      reg_ptr <= 8'h00;
      addr_ok <= 1'b0;
      ack_is_mine <= 1'b0;
      control <= pms_pkg::CONTROL_RESET;
    end else if (sel_n || phase == PMS_P_RESET) begin
      state <= PMS_S_IDLE; // RQ1
      if (phase == PMS_P_RESET) begin
        control <= pms_pkg::CONTROL_RESET; // RQ4
      end
    end else if (start_c) begin
      state <= PMS_S_ADDR; // RQ3
      bitn <= 4'h0;
    end else if (stop_c) begin
      state <= PMS_S_IDLE;
    end else if (scl_rise && state inside {PMS_S_ADDR, PMS_S_REG, PMS_S_WDATA}) begin
      shift <= {shift[6:0], sda};
      bitn <= bitn + 4'h1;
      if (bitn == 4'd7) begin
        ack_is_mine <= 1'b1;
        unique case (state)
          PMS_S_ADDR: begin
            addr_ok <= ({shift[6:0], sda} >> 1) == 8'(pms_pkg::DEV_ADDR);
            after_ack <= sda ? PMS_S_RDATA : PMS_S_REG;
            ack_is_mine <= ({shift[6:0], sda} >> 1) == 8'(pms_pkg::DEV_ADDR);
          end
          PMS_S_REG: begin
            reg_ptr <= {shift[6:0], sda};
            after_ack <= PMS_S_WDATA;
          end
          default: begin
            if (reg_ptr == pms_pkg::ADDR_CONTROL) begin
              control <= {shift[6:0], sda};
            end
            reg_ptr <= reg_ptr + 8'h01;
            after_ack <= PMS_S_WDATA;
          end
        endcase
        state <= PMS_S_WAIT;
      end
    end else if (scl_fall && state == PMS_S_WAIT) begin
      state <= PMS_S_ACK;
      bitn <= 4'h0;
    end else if (scl_fall && state == PMS_S_ACK) begin
      state <= addr_ok ? after_ack : PMS_S_IDLE;
      if (after_ack == PMS_S_RDATA) begin
        shift <= map_read(reg_ptr, not_ready, high_power, flags, control);
      end
    end else if (scl_fall && state == PMS_S_RDATA) begin
      shift <= {shift[6:0], 1'b1};
      bitn <= bitn + 4'h1;
      if (bitn == 4'd7) begin
        reg_ptr <= reg_ptr + 8'h01;
        ack_is_mine <= 1'b0;
        state <= PMS_S_WAIT;
        after_ack <= PMS_S_RDATA;
      end
    end
  end

  // data line: only pulled low, released otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link.sda_mod_o <= 1'b0;
      link.sda_mod_oe <= 1'b0;
    end else begin
      link.sda_mod_o <= 1'b0;
      link.sda_mod_oe <= !sel_n && ((state == PMS_S_ACK && ack_is_mine) ||
        (state == PMS_S_RDATA && !shift[7])); // RQ1 RQ3
    end
  end

  // ----------------------------------------------------------------
  // latched flags and interrupt line
  // ----------------------------------------------------------------
  // writing a one clears a flag; a new event in that cycle wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (flag_clr && |(({shift[6:0], sda} >> i) & 8'h01)) begin
          flags[i] <= 1'b0;
        end
      end
      if (phase == PMS_P_RESET) begin
        flags <= 8'h00;
      end
      if (phase == PMS_P_INIT && init_cnt == 16'(INIT_TIME)) begin
        flags[pms_pkg::FLAG_RESET_DONE] <= 1'b1; // RQ6
      end
      if (fault_event && phase == PMS_P_READY) begin
        flags[pms_pkg::FLAG_FAULT] <= 1'b1; // RQ13
      end
    end
  end

  // open drain: enable pulls low, never drives high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link.interrupt_n_oe <= 1'b0;
      link.module_present_n <= 1'b0;
    end else begin
      link.interrupt_n_oe <= (flags != 8'h00); // RQ13 RQ15
      link.module_present_n <= 1'b0; // RQ12
    end
  end
endmodule : pms_module_end

// >>> pms_host_end.sv
// module: host board controller for the module sideband pins
`timescale 1ns/10ps
module pms_host_end (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  // link pins
  pms_link_if.host_end link
);
  typedef enum logic [2:0] {PMH_IDLE, PMH_START, PMH_BIT, PMH_STOP} pmh_state_t;
  logic int_lvl;
  logic prs_lvl;
  logic sda_lvl;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic busy;
  logic [7:0] rd_byte;
  logic [26:0] frame;
  logic [4:0] nbits;
  logic is_read;
  logic [7:0] half_cnt;
  logic phase2;
  pmh_state_t st;
  logic done_pulse;
  logic int_d;
  logic prs_d;
  // ----------------------------------------------------------------
  // pin inputs
  // ----------------------------------------------------------------
  pms_sync #(.INIT(1'b1)) u_int (.clk(clk), .nrst(nrst), .pin(link.interrupt_n),
    .level(int_lvl));
  pms_sync #(.INIT(1'b1)) u_prs (.clk(clk), .nrst(nrst), .pin(link.module_present_n),
    .level(prs_lvl));
  pms_sync #(.INIT(1'b1)) u_sda (.clk(clk), .nrst(nrst), .pin(link.sda), .level(sda_lvl));

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  wire cmd_go = wr && addr == pms_pkg::REG_CMD && !busy;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h00000000;
      irq_mask <= 3'h0;
      link.module_select_n <= 1'b1;
      link.module_reset_n <= 1'b1;
      link.init_control_select <= 1'b1;
      link.init_control_select_oe <= 1'b0;
    end else begin
      rdata <= 32'h00000000;
      if (rd) begin
        unique case (addr)
          pms_pkg::REG_CMD: rdata <= {31'h0, busy};
          pms_pkg::REG_RDATA: rdata <= {24'h0, rd_byte};
          pms_pkg::REG_IRQ_STATUS: rdata <= {29'h0, irq_status};
          pms_pkg::REG_IRQ_MASK: rdata <= {29'h0, irq_mask};
          pms_pkg::REG_PINS: rdata <= {26'h0, !prs_lvl, !int_lvl, link.init_control_select_oe,
            link.init_control_select, !link.module_reset_n, !link.module_select_n};
          default: rdata <= 32'h00000000;
        endcase
      end
      if (wr && addr == pms_pkg::REG_IRQ_MASK) begin
        irq_mask <= wdata[2:0];
      end
      // each module gets its own select line; init level is set only while absent
      if (wr && addr == pms_pkg::REG_PINS) begin
        link.module_select_n <= !wdata[0]; // RQ2
        link.module_reset_n <= !wdata[1];
        if (prs_lvl) begin
          link.init_control_select <= wdata[2]; // RQ11
          link.init_control_select_oe <= wdata[3];
        end
      end
    end
  end

  // sticky events; set wins over the write-one clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_status <= 3'h0;
      int_d <= 1'b1;
      prs_d <= 1'b1;
      irq <= 1'b0;
    end else begin
      int_d <= int_lvl;
      prs_d <= prs_lvl;
      irq <= |(irq_status & irq_mask);
      for (int i = 0; i < 3; i++) begin
        if (wr && addr == pms_pkg::REG_IRQ_STATUS && wdata[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
      if (done_pulse) begin
        irq_status[pms_pkg::IRQ_DONE] <= 1'b1;
      end
      if (int_d && !int_lvl) begin
        irq_status[pms_pkg::IRQ_ATTN] <= 1'b1; // RQ14
      end
      if (prs_d != prs_lvl) begin
        irq_status[pms_pkg::IRQ_PRESENT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // two-wire master: one byte read or write per command
  // ----------------------------------------------------------------
  // frame: addr+rw, ack, reg, ack, data, ack (27 bits) or addr+rw, ack, rdata, ack (18 bits), msb first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= PMH_IDLE;
      busy <= 1'b0;
      frame <= 27'h0;
      nbits <= 5'h0;
      is_read <= 1'b0;
      half_cnt <= 8'h00;
      phase2 <= 1'b0;
      rd_byte <= 8'h00;
      done_pulse <= 1'b0;
      link.scl <= 1'b1;
      link.scl_oe <= 1'b0;
      link.sda_host_o <= 1'b1;
      link.sda_host_oe <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      if (half_cnt != 8'h00) begin
        half_cnt <= half_cnt - 8'h01;
      end
      unique case (st)
        PMH_IDLE: begin
          if (cmd_go) begin
            busy <= 1'b1;
            is_read <= wdata[8];
            frame <= wdata[8] ? {pms_pkg::DEV_ADDR[6:0], 1'b1, 1'b1, 18'h3ffff}
              : {pms_pkg::DEV_ADDR[6:0], 1'b0, 1'b1, wdata[7:0], 1'b1, wdata[23:16], 1'b1};
            nbits <= wdata[8] ? 5'd18 : 5'd27;
            link.scl_oe <= 1'b1;
            link.sda_host_oe <= 1'b1;
            link.sda_host_o <= 1'b0; // start: data falls while clock high
            half_cnt <= 8'(pms_pkg::SCL_HALF_CYCLES);
            st <= PMH_START;
          end
        end
        PMH_START: begin
          if (half_cnt == 8'h00) begin
            link.scl <= 1'b0;
            phase2 <= 1'b0;
            half_cnt <= 8'(pms_pkg::SCL_HALF_CYCLES);
            st <= PMH_BIT;
          end
        end
        PMH_BIT: begin
          // data moves mid-way through the low half, clear of both clock edges
          if (!phase2 && half_cnt == 8'(pms_pkg::SCL_HALF_CYCLES / 2)) begin
            link.sda_host_o <= frame[26];
          end else if (half_cnt == 8'h00 && !phase2) begin
            link.scl <= 1'b1;
            phase2 <= 1'b1;
            half_cnt <= 8'(pms_pkg::SCL_HALF_CYCLES);
          end else if (half_cnt == 8'h00) begin
            // the closing acknowledge bit is not data, so it is not shifted in
            if (nbits != 5'h1) begin
              rd_byte <= {rd_byte[6:0], sda_lvl};
            end
            frame <= {frame[25:0], 1'b1};
            nbits <= nbits - 5'h1;
            link.scl <= 1'b0;
            phase2 <= 1'b0;
            half_cnt <= 8'(pms_pkg::SCL_HALF_CYCLES);
            if (nbits == 5'h1) begin
              link.sda_host_o <= 1'b0;
              st <= PMH_STOP;
            end
          end
        end
        PMH_STOP: begin
          if (half_cnt == 8'h00 && !link.scl) begin
            link.scl <= 1'b1;
            half_cnt <= 8'(pms_pkg::SCL_HALF_CYCLES);
          end else if (half_cnt == 8'h00) begin
            link.sda_host_o <= 1'b1;
            link.sda_host_oe <= 1'b0;
            link.scl_oe <= 1'b0;
            busy <= 1'b0;
            done_pulse <= 1'b1;
            if (is_read) begin
              rd_byte <= rd_byte;
            end
            st <= PMH_IDLE;
          end
        end
        default: st <= PMH_IDLE;
      endcase
    end
  end
endmodule : pms_host_end

// >>> pms_chk.sv
// checker: wire-level properties of the sideband link between the two ends
`timescale 1ns/10ps
module pms_chk #(
  parameter int unsigned INIT_TIME = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link pins
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic scl_pin,
  input wire logic module_present_n,
  input wire logic interrupt_n_oe,
  input wire logic interrupt_n,
  input wire logic sda_mod_o,
  input wire logic sda_mod_oe
);
  logic [15:0] up_cnt;
  wire mod_low = sda_mod_oe && !sda_mod_o;
  // cycles since reset release, saturating so it never wraps into a false match
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      up_cnt <= 16'h0;
    end else if (up_cnt < 16'(INIT_TIME + 9)) begin
      up_cnt <= up_cnt + 16'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_unselected;
    module_select_n [*8] |-> !mod_low;
  endproperty
  a_unselected: assert property (p_unselected) else $error("data pulled while unselected");
  property p_data_edge;
    $changed(mod_low) |-> !scl_pin;
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data moved with clock high");
  property p_long_reset;
    (!module_reset_n) [*8] ##1 (!module_reset_n) [*8] |-> !interrupt_n_oe;
  endproperty
  a_long_reset: assert property (p_long_reset) else $error("flags kept in reset");
  property p_short_pulse;
    $fell(module_reset_n) ##1 !module_reset_n ##1 module_reset_n |->
      not (##[1:30] $changed(interrupt_n_oe));
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse acted");
  property p_powerup_done;
    up_cnt == 16'(INIT_TIME + 8) |-> interrupt_n_oe;
  endproperty
  a_powerup_done: assert property (p_powerup_done) else $error("no done after power-up");
  property p_not_early;
    up_cnt < 16'(INIT_TIME) |-> !interrupt_n_oe;
  endproperty
  a_not_early: assert property (p_not_early) else $error("done posted too early");
  property p_present;
    !module_present_n;
  endproperty
  a_present: assert property (p_present) else $error("presence line released");
  property p_open_drain;
    interrupt_n == !interrupt_n_oe;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("interrupt line level wrong");
endmodule : pms_chk

// >>> test_pluggable_module_sideband_control.sv
// testbench: host and module ends joined over the sideband link
`timescale 1ns/10ps
module test_pluggable_module_sideband_control;
  logic clk;
  logic nrst;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic fault_event;
  logic [31:0] rdata;
  logic irq;
  logic high_power;
  logic [31:0] v;
  logic irq_a;
  int bad_count;
  int checks;
  int cyc;
  pms_link_if link ();
  pms_host_end pms_host_end_inst (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .link(link));
  // short counts keep the reset and init phases brief
  pms_module_end #(.RESET_MIN(8), .INIT_TIME(16)) pms_module_end_inst (.clk(clk),
    .nrst(nrst), .link(link), .fault_event(fault_event), .high_power(high_power));
  pms_chk #(.INIT_TIME(16)) pms_chk_inst (.clk(clk), .nrst(nrst),
    .module_select_n(link.module_select_n), .module_reset_n(link.module_reset_n),
    .scl_pin(link.scl_pin), .module_present_n(link.module_present_n),
    .interrupt_n_oe(link.interrupt_n_oe), .interrupt_n(link.interrupt_n),
    .sda_mod_o(link.sda_mod_o), .sda_mod_oe(link.sda_mod_oe));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (exp !== got) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : check
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd
  // one link transfer, busy polled under a bound
  task automatic xfer(input logic [31:0] cmd);
    reg_wr(pms_pkg::REG_CMD, cmd);
    v = 32'h1;
    for (int i = 0; i < 8000 && v[0] !== 1'b0; i++) begin
      reg_rd(pms_pkg::REG_CMD, v);
    end
    check("busy", 32'h0, 32'(v[0]));
  endtask : xfer
  task automatic results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard: the run needs just under half of this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    fault_event = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (40) @(posedge clk);
    reg_rd(pms_pkg::REG_PINS, v);
    check("present", 32'h1, 32'(v[5]));
    check("done low", 32'h1, 32'(v[4]));
    check("power", 32'h0, 32'(high_power));
    xfer(32'h0001_0003);
    reg_rd(pms_pkg::REG_PINS, v);
    check("unselected", 32'h1, 32'(v[4]));
    reg_wr(pms_pkg::REG_PINS, 32'h1);
    xfer(32'h0001_0003);
    repeat (10) @(posedge clk);
    reg_rd(pms_pkg::REG_PINS, v);
    check("done clear", 32'h0, 32'(v[4]));
    xfer(32'h0001_001a);
    repeat (10) @(posedge clk);
    check("power on", 32'h1, 32'(high_power));
    // two-cycle reset pulse must be filtered out
    reg_wr(pms_pkg::REG_PINS, 32'h3);
    reg_wr(pms_pkg::REG_PINS, 32'h1);
    repeat (30) @(posedge clk);
    check("short pulse", 32'h1, 32'(high_power));
    // a pending fault flag must be wiped by the long reset below
    fault_event <= 1'b1;
    @(posedge clk);
    fault_event <= 1'b0;
    reg_wr(pms_pkg::REG_PINS, 32'h3);
    repeat (30) @(posedge clk);
    check("long reset", 32'h0, 32'(high_power));
    reg_wr(pms_pkg::REG_PINS, 32'h1);
    // status is ignored until the done interrupt shows
    repeat (60) @(posedge clk);
    reg_rd(pms_pkg::REG_PINS, v);
    check("done again", 32'h1, 32'(v[4]));
    check("defaults", 32'h0, 32'(high_power));
    xfer(32'h0001_0003);
    reg_wr(pms_pkg::REG_IRQ_STATUS, 32'h7);
    reg_rd(pms_pkg::REG_IRQ_STATUS, v);
    check("irq cleared", 32'h0, v);
    @(posedge clk);
    fault_event <= 1'b1;
    @(posedge clk);
    fault_event <= 1'b0;
    repeat (20) @(posedge clk);
    reg_rd(pms_pkg::REG_PINS, v);
    check("fault low", 32'h1, 32'(v[4]));
    reg_rd(pms_pkg::REG_IRQ_STATUS, v);
    check("irq fell", 32'h2, v);
    reg_wr(pms_pkg::REG_IRQ_MASK, 32'h2);
    repeat (3) @(posedge clk);
    irq_a = irq;
    reg_wr(pms_pkg::REG_IRQ_MASK, 32'h0);
    repeat (3) @(posedge clk);
    check("mask on", 32'h1, 32'(irq_a));
    check("mask off", 32'h0, 32'(irq));
    reg_wr(pms_pkg::REG_IRQ_STATUS, 32'h2);
    repeat (3) @(posedge clk);
    check("irq off", 32'h0, 32'(irq));
    // pointer lands on the flags byte after the status write
    xfer(32'h0000_0002);
    xfer(32'h0000_0100);
    reg_rd(pms_pkg::REG_RDATA, v);
    check("flags read", 32'h2, 32'(v[7:0]));
    results();
  end
endmodule : test_pluggable_module_sideband_control
